// ---- rtl/iar_remap.sv ----
// Alias decoder and address remap for the I2C pass-through, with an AHB-Lite slave.
`timescale 1ns/1ps
`default_nettype none
`include "iar_defines.svh"
// Notes on behaviour
// - Each slot holds a writable 7-bit alias in bits 7:1, reset zero.
// - A matching address is replaced by that slot's physical target address.
// - An alias of zero disables its slot entirely.
// - Bit 0 set forces ack on writes to that slot; clear keeps force_ack low, and remote_ack is not used.
// - Physical target address lives in bits 7:1 of a companion register.
module iar_remap #(
   parameter int SLOTS = 5
) (
   input wire logic hclk, // Clock, 200 MHz.
   input wire logic hresetn, // Asynchronous reset, active low.
   input wire logic hsel, // Slave select.
   input wire logic [31:0] haddr, // Byte address.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write when high.
   input wire logic [2:0] hsize, // Transfer size.
   input wire logic [31:0] hwdata, // Write data.
   input wire logic hready, // Bus ready.
   output logic hreadyout, // Slave ready.
   output logic hresp, // Always OKAY.
   output logic [31:0] hrdata, // Read data.
   input wire logic req_valid, // Incoming transaction address valid, one-cycle pulse.
   input wire iar_pkg::iar_addr7_t req_addr, // Incoming 7-bit address.
   input wire logic req_write, // Incoming transaction is a write.
   input wire logic remote_ack, // Acknowledge returned by the remote side.
   output logic fwd_valid, // Forward pulse toward the remote side.
   output iar_pkg::iar_addr7_t fwd_addr, // Remapped physical address.
   output logic fwd_write, // Forwarded transaction is a write.
   output logic [2:0] fwd_slot, // Slot that matched.
   output logic hit_q_out, // Last lookup matched a slot.
   output logic force_ack // Level: acknowledge forced for current slot.
);
   import iar_pkg::*;
   logic [SLOTS*8-1:0] alias_flat;
   logic [SLOTS*8-1:0] phys_flat;
   logic [7:0] rd_data;
   iar_bus_state_t st_q;
   logic wr_pend_q;
   logic [7:0] wr_idx_q;
   logic [7:0] rd_idx_q;
   // Address phase decode: word index is the byte address divided by four.
   wire [7:0] a_idx = haddr[9:2];
   wire a_valid = hsel && hready && htrans[1];
   wire a_alias = (a_idx >= `IAR_IDX_ALIAS_SLOT1) && (a_idx <= `IAR_IDX_ALIAS_SLOT5);
   wire [7:0] phys_last = `IAR_IDX_PHYS_SLOT1 + 8'(SLOTS - 1);
   wire a_phys = (a_idx >= `IAR_IDX_PHYS_SLOT1) && (a_idx <= phys_last);
   wire w_alias = (wr_idx_q >= `IAR_IDX_ALIAS_SLOT1) && (wr_idx_q <= `IAR_IDX_ALIAS_SLOT5);
   wire w_phys = (wr_idx_q >= `IAR_IDX_PHYS_SLOT1) && (wr_idx_q <= phys_last);
   wire [7:0] w_off = w_alias ? (wr_idx_q - `IAR_IDX_ALIAS_SLOT1) : (wr_idx_q - `IAR_IDX_PHYS_SLOT1);
   wire [7:0] r_off = a_alias ? (a_idx - `IAR_IDX_ALIAS_SLOT1) : (a_idx - `IAR_IDX_PHYS_SLOT1);
   wire wr_go = wr_pend_q && (w_alias || w_phys);
   // The slave is zero wait state; writes land at the end of the data phase.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   // Bus phase tracking; unmapped indices read zero and writes to them are dropped.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= IAR_IDLE;
         wr_pend_q <= 1'b0;
         wr_idx_q <= 8'h00;
         rd_idx_q <= 8'h00;
      end else begin
         st_q <= a_valid ? IAR_DATA : IAR_IDLE;
         wr_pend_q <= a_valid && hwrite;
         wr_idx_q <= a_idx;
         rd_idx_q <= a_idx;
      end
   end
   iar_slot_regs #(.SLOTS(SLOTS)) u_regs (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr_en(wr_go),
      .wr_phys(w_phys),
      .wr_slot(w_off[2:0]),
      .wr_data(hwdata[7:0]),
      .rd_slot(r_off[2:0]),
      .rd_phys(a_phys),
      .rd_data(rd_data),
      .alias_flat(alias_flat),
      .phys_flat(phys_flat)
   );
   // Lookup: priority goes to the lowest slot if software programs duplicates.
   logic [SLOTS-1:0] match;
   for (genvar g = 0; g < SLOTS; g++) begin : g_match
      wire [6:0] al = alias_flat[g*8+`IAR_ADDR_LSB +: 7];
      assign match[g] = (al != 7'h00) && (al == req_addr);
   end
   logic [2:0] hit_slot;
   always_comb begin
      hit_slot = 3'd0;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (match[i]) begin
            hit_slot = 3'(i);
         end
      end
   end
   wire any_hit = |match;
   wire [7:0] hit_alias = alias_flat[hit_slot*8 +: 8];
   wire [7:0] hit_phys = phys_flat[hit_slot*8 +: 8];
   logic st_hit_q;
   logic [2:0] st_slot_q;
   logic fack_q;
   logic last_wr_q;
   // Forward stage: only matching transactions leave, with the physical address.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fwd_valid <= 1'b0;
         fwd_addr <= 7'h00;
         fwd_write <= 1'b0;
         fwd_slot <= 3'd0;
         st_hit_q <= 1'b0;
         st_slot_q <= 3'd0;
         fack_q <= 1'b0;
         last_wr_q <= 1'b0;
      end else if (req_valid) begin
         fwd_valid <= any_hit;
         fwd_addr <= any_hit ? hit_phys[`IAR_ADDR_MSB:`IAR_ADDR_LSB] : 7'h00;
         fwd_write <= req_write;
         fwd_slot <= hit_slot;
         st_hit_q <= any_hit;
         st_slot_q <= hit_slot;
         fack_q <= any_hit && hit_alias[`IAR_FACK_BIT];
         last_wr_q <= req_write;
      end else begin
         fwd_valid <= 1'b0;
      end
   end
   // Forced ack applies to writes only; force_ack stays low after a read lookup.
   assign force_ack = fack_q && last_wr_q;
   assign hit_q_out = st_hit_q;
   wire [31:0] status_word = {27'h0, st_slot_q, force_ack, st_hit_q};
   wire rd_reg = (rd_idx_q >= `IAR_IDX_ALIAS_SLOT1 && rd_idx_q <= `IAR_IDX_ALIAS_SLOT5) ||
                 (rd_idx_q >= `IAR_IDX_PHYS_SLOT1 && rd_idx_q <= phys_last);
   // Read mux in the data phase; bits above the byte read as zero.
   assign hrdata = (st_q != IAR_DATA) ? 32'h0 :
                   rd_reg ? {24'h0, rd_data} :
                   (rd_idx_q == `IAR_IDX_STATUS) ? status_word : 32'h0;
   wire unused = &{1'b0, hsize, haddr[31:10], haddr[1:0], htrans[0], hwdata[31:8], remote_ack};
endmodule
`default_nettype wire

// ---- rtl/iar_defines.svh ----
// Constants for the remote alias remap block: register indices, fields, resets, timing.
`ifndef IAR_DEFINES_SVH
`define IAR_DEFINES_SVH
// Printed offsets are register indices; byte address is four times the index.
`define IAR_IDX_ALIAS_SLOT1 8'h42
`define IAR_IDX_ALIAS_SLOT2 8'h43
`define IAR_IDX_ALIAS_SLOT3 8'h44
`define IAR_IDX_ALIAS_SLOT4 8'h45
`define IAR_IDX_ALIAS_SLOT5 8'h46
// Physical target address register of slot 1 sits at this index; slots 2..5 follow it.
`define IAR_IDX_PHYS_SLOT1 8'h3A
// Status register showing the last lookup result.
`define IAR_IDX_STATUS 8'h50
`define IAR_ADDR_MSB 7
`define IAR_ADDR_LSB 1
`define IAR_FACK_BIT 0
`define IAR_RESET_VAL 8'h00
`define IAR_LOOKUP_LAT 1
`endif

// ---- rtl/iar_pkg.sv ----
// Types for the remote alias remap block.
package iar_pkg;
   typedef logic [6:0] iar_addr7_t;
   typedef logic [7:0] iar_reg8_t;
   typedef enum logic [1:0] {
      IAR_IDLE = 2'b00,
      IAR_DATA = 2'b01
   } iar_bus_state_t;
endpackage

// ---- rtl/iar_slot_regs.sv ----
// Per-slot alias and physical target register store with registered read data.
`timescale 1ns/1ps
`default_nettype none
module iar_slot_regs #(
   parameter int SLOTS = 5
) (
   input wire logic hclk, // Clock.
   input wire logic hresetn, // Asynchronous reset, active low.
   input wire logic wr_en, // Write strobe.
   input wire logic wr_phys, // High selects the physical bank.
   input wire logic [2:0] wr_slot, // Slot index written.
   input wire logic [7:0] wr_data, // Write data.
   input wire logic [2:0] rd_slot, // Slot index read.
   input wire logic rd_phys, // High reads the physical bank.
   output logic [7:0] rd_data, // Registered read data.
   output logic [SLOTS*8-1:0] alias_flat, // All alias registers.
   output logic [SLOTS*8-1:0] phys_flat // All physical registers.
);
   import iar_pkg::*;
   // One alias and one physical register per slot; bit 0 of physical reads zero.
   for (genvar g = 0; g < SLOTS; g++) begin : g_slot
      iar_reg8_t alias_q;
      iar_reg8_t phys_q;
      wire hit = wr_en && (wr_slot == 3'(g));
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            alias_q <= `IAR_RESET_VAL;
            phys_q <= `IAR_RESET_VAL;
         end else if (hit && !wr_phys) begin
            alias_q <= wr_data;
         end else if (hit && wr_phys) begin
            phys_q <= {wr_data[7:1], 1'b0};
         end
      end
      assign alias_flat[g*8 +: 8] = alias_q;
      assign phys_flat[g*8 +: 8] = phys_q;
   end
   // Read data is registered so the bus sees a clean value in the data phase.
   wire [7:0] rd_sel = rd_phys ? phys_flat[rd_slot*8 +: 8] : alias_flat[rd_slot*8 +: 8];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= rd_sel;
      end
   end
endmodule
`default_nettype wire

// ---- verif/iar_far_model.sv ----
// Local controller model that issues address lookups.
`timescale 1ns/1ps
`default_nettype none
module iar_far_model (
   input wire logic hclk, // Clock.
   output logic req_valid = 1'b0, // Lookup pulse.
   output iar_pkg::iar_addr7_t req_addr = 7'h55, // Looked-up address.
   output logic req_write = 1'b0, // Write flag.
   output logic remote_ack = 1'b0 // Remote answer.
);
   import iar_pkg::*;
   // Nothing pulls the answer to a level, so it toggles every cycle.
   always @(posedge hclk) remote_ack <= ~remote_ack;
   // One-cycle request; the address is scrambled once it is no longer valid.
   task automatic send(input iar_addr7_t a, input logic w);
      @(posedge hclk);
      req_valid <= 1'b1;
      req_addr <= a;
      req_write <= w;
      @(posedge hclk);
      req_valid <= 1'b0;
      req_addr <= ~a;
      req_write <= ~w;
   endtask
endmodule
`default_nettype wire

// ---- verif/iar_remap_monitor.sv ----
// Checker of the alias lookup outputs.
`timescale 1ns/1ps
`default_nettype none
module iar_remap_monitor (
   input wire logic hclk, // Clock.
   input wire logic hresetn, // Reset, active low.
   input wire logic req_valid, // Lookup pulse.
   input wire iar_pkg::iar_addr7_t req_addr, // Looked-up address.
   input wire logic fwd_valid, // Forward pulse.
   input wire logic fwd_write, // Forwarded write.
   input wire logic [2:0] fwd_slot, // Matched slot.
   input wire logic hit_q_out, // Last lookup hit.
   input wire logic force_ack // Forced acknowledge.
);
   import iar_pkg::*;
   // One clock domain, so clock and reset are given once.
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_FWD_CAUSE: assert property (fwd_valid |-> $past(req_valid))
      else $error("forward pulse without a request");
   AST_ZERO_OFF: assert property (req_valid && req_addr == 7'h00 |=> !fwd_valid)
      else $error("address zero was forwarded");
   AST_HIT: assert property (fwd_valid |-> hit_q_out)
      else $error("forward without hit");
   AST_HOLD: assert property (!req_valid |=> $stable(hit_q_out) && $stable(fwd_slot))
      else $error("lookup result moved without a request");
   AST_FACK: assert property (force_ack |-> hit_q_out && fwd_write)
      else $error("forced ack without a matched write");
   AST_SLOT: assert property (hit_q_out |-> fwd_slot <= 3'h4)
      else $error("matched slot out of range");
endmodule
bind iar_remap iar_remap_monitor mon (.hclk, .hresetn, .req_valid, .req_addr, .fwd_valid,
   .fwd_write, .fwd_slot, .hit_q_out, .force_ack);
`default_nettype wire

// ---- verif/i2c_remote_alias_remap_test.sv ----
// Self-checking bench for the alias remap block.
`timescale 1ns/1ps
`default_nettype none
`include "iar_defines.svh"
module i2c_remote_alias_remap_test;
   import iar_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b1;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic hreadyout, hresp, req_valid, req_write, remote_ack, fwd_valid;
   logic fwd_write, hit_q_out, force_ack;
   logic [2:0] fwd_slot;
   iar_addr7_t req_addr, fwd_addr;
   int n_errors = 0;
   int n_checks = 0;
   iar_remap #(.SLOTS(5)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .req_valid, .req_addr,
      .req_write, .remote_ack, .fwd_valid, .fwd_addr, .fwd_write, .fwd_slot, .hit_q_out,
      .force_ack);
   iar_far_model far (.hclk, .req_valid, .req_addr, .req_write, .remote_ack);
   // Clock at 200 MHz.
   initial begin
      forever #2.5 hclk = ~hclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Single word transfer; the bus is waited on, never counted.
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= {22'h000000, idx, 2'h0};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic look(input iar_addr7_t a, input logic w, input logic h, input iar_addr7_t p,
      input logic f);
      far.send(a, w);
      #1;
      chk(fwd_valid, h);
      chk(hit_q_out, h);
      if (h) chk(fwd_addr, p);
      if (h) chk(fwd_write, w);
      chk(force_ack, f);
   endtask
   task automatic t_reset;
      logic [7:0] s;
      for (s = 8'h00; s < 8'h05; s++) begin
         bus(1'b0, `IAR_IDX_ALIAS_SLOT1 + s, 32'h0);
         chk(rd, 32'h0);
      end
      bus(1'b1, 8'hFF, 32'hA5);
      bus(1'b0, 8'hFF, 32'h0);
      chk(rd, 32'h0);
      chk(hresp, 1'b0);
      chk(hreadyout, 1'b1);
      $display("reset test done");
   endtask
   task automatic t_remap;
      logic [7:0] s;
      for (s = 8'h00; s < 8'h05; s++) begin
         bus(1'b1, `IAR_IDX_ALIAS_SLOT1 + s, {24'h0, 7'h10 + s[6:0], 1'b0});
         bus(1'b1, `IAR_IDX_PHYS_SLOT1 + s, {24'h0, 7'h60 + s[6:0], 1'b0});
         bus(1'b0, `IAR_IDX_ALIAS_SLOT1 + s, 32'h0);
         chk(rd, {24'h0, 7'h10 + s[6:0], 1'b0});
         bus(1'b0, `IAR_IDX_PHYS_SLOT1 + s, 32'h0);
         chk(rd, {24'h0, 7'h60 + s[6:0], 1'b0});
         look(7'h10 + s[6:0], 1'b1, 1'b1, 7'h60 + s[6:0], 1'b0);
      end
      look(7'h7F, 1'b1, 1'b0, 7'h00, 1'b0);
      $display("remap test done");
   endtask
   task automatic t_zero;
      bus(1'b1, `IAR_IDX_ALIAS_SLOT3, 32'h0);
      look(7'h12, 1'b1, 1'b0, 7'h00, 1'b0);
      look(7'h00, 1'b1, 1'b0, 7'h00, 1'b0);
      $display("zero alias test done");
   endtask
   task automatic t_fack;
      bus(1'b1, `IAR_IDX_ALIAS_SLOT2, 32'h23);
      look(7'h11, 1'b1, 1'b1, 7'h61, 1'b1);
      bus(1'b0, `IAR_IDX_STATUS, 32'h0);
      chk(rd, 32'h7);
      look(7'h11, 1'b0, 1'b1, 7'h61, 1'b0);
      bus(1'b1, `IAR_IDX_ALIAS_SLOT2, 32'h22);
      look(7'h11, 1'b1, 1'b1, 7'h61, 1'b0);
      bus(1'b0, `IAR_IDX_STATUS, 32'h0);
      chk(rd, 32'h5);
      $display("forced ack test done");
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // A hang counts as a failure; the run needs well under this span.
   initial begin
      #20000;
      n_errors++;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_remap;
      t_zero;
      t_fack;
      end_sim;
   end
endmodule
`default_nettype wire
